// ---- hw/dcs_regs.vh ----
// Constants for the dual clock switch and pre-divider block.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef DCS_REGS_VH
`define DCS_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define DCS_ADDR_CTRL   4'h0
`define DCS_ADDR_STATUS 4'h1
`define DCS_ADDR_MASK   4'h2
`define DCS_ADDR_STATE  4'h3

// ****************************************
// Field positions
// ****************************************
`define DCS_CTRL_IE     0
`define DCS_CTRL_HRE    1
`define DCS_CTRL_BOOST  2
`define DCS_ST_WAKE     0
`define DCS_ST_START7   1
`define DCS_ST_FASTDONE 2
`define DCS_ST_SLOWDONE 3
`define DCS_TAP_ELEVEN  10
`define DCS_TAP_FOURTEEN 13
`define DCS_TAP_FIFTEEN 14

// ****************************************
// Reset values
// ****************************************
`define DCS_CTRL_RST    3'h4
`define DCS_STATUS_RST  4'h0
`define DCS_MASK_RST    4'h0
`define DCS_PDIV_RST    15'h0000

// ****************************************
// Build options and counts
// ****************************************
`define DCS_COMBO_DUAL  2'h0
`define DCS_COMBO_SLOW  2'h1
`define DCS_COMBO_FAST  2'h2
`define DCS_FREQ_250K   10'h0FA
`define DCS_FREQ_500K   10'h1F4
`define DCS_FAST_HOLD   4'hC
`define DCS_SLOW_HOLD   4'h2
`define DCS_CLR_OPERAND 12'h100

`endif

// ---- hw/dcs_clock_switch.v ----
// Base clock selection, oscillator control and 15-stage pre-divider.
// Assumes oscillator clocks arrive as pins far slower than clk_i,
// and core instruction strobes are one-cycle pulses on clk_i.
//
// Behaviour
// - Internal RC fast oscillator: 250 or 500 kHz
// - Dual: instructions switch base clock source
// - Dual: halt or stop returns to slow
// - Dual: peripherals always use slow oscillator
// - Fast select waits 12 fast cycles
// - Slow select waits 2 slow cycles
// - Single option: select instructions do nothing
// - Single option: boost set before stop
// - Pre-divider 15 stages, advances on fall
// - Upper five stages clear on reset, clear instruction
// - Stage fourteen raises wake request flag
// - Wake flag plus enable gives interrupt
// - Wake plus halt enable releases halt
// - Fast only: pre-divider input base/1,4,8,16
// - Fast oscillator stops on return to slow
// - Slow oscillator runs, stopped in stop; always off in fast only
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.vh"

module dcs_clock_switch #(
	parameter [1:0] CLOCK_COMBO  = 2'h0,
	parameter [9:0] FAST_FREQ    = 10'h0FA,
	parameter [4:0] PH0_DIV      = 5'h01
) (
	input  wire        clk_i,
	input  wire        sys_rst_i,
	input  wire        low_rate_oscillator_clock_i,
	input  wire        high_rate_oscillator_clock_i,
	input  wire        fast_select_i,
	input  wire        slow_select_i,
	input  wire        halt_i,
	input  wire        stop_i,
	input  wire        stop_exit_i,
	input  wire        predivider_clear_instruction_i,
	input  wire [11:0] clear_operand_i,
	input  wire [3:0]  reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [7:0]  reg_rdata_o,
	output reg         base_clk_o,
	output reg         base_on_fast_o,
	output reg         high_rate_oscillator_en_o,
	output reg         fast_freq_500k_o,
	output reg         low_rate_oscillator_en_o,
	output reg         oscillator_boost_flag_o,
	output reg         periph_tick_o,
	output reg  [14:0] predivider_o,
	output reg         halt_release_o,
	output reg         irq_o
);

	// ****************************************
	// Fixed configuration
	// ****************************************
	localparam IS_DUAL = (CLOCK_COMBO == `DCS_COMBO_DUAL);
	localparam IS_FAST = (CLOCK_COMBO == `DCS_COMBO_FAST);
	localparam [4:0] DIV_LAST = PH0_DIV - 5'h01;

	localparam [2:0] ST_SLOW      = 3'h0;
	localparam [2:0] ST_FAST_WAIT = 3'h1;
	localparam [2:0] ST_FAST_SWAP = 3'h2;
	localparam [2:0] ST_FAST      = 3'h3;
	localparam [2:0] ST_SLOW_WAIT = 3'h4;
	localparam [2:0] ST_SLOW_SWAP = 3'h5;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg slow_s1_reg;
	reg slow_s2_reg;
	reg slow_s3_reg;
	reg fast_s1_reg;
	reg fast_s2_reg;
	reg fast_s3_reg;

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			slow_s1_reg <= 1'b0;
			slow_s2_reg <= 1'b0;
			slow_s3_reg <= 1'b0;
			fast_s1_reg <= 1'b0;
			fast_s2_reg <= 1'b0;
			fast_s3_reg <= 1'b0;
		end else begin
			slow_s1_reg <= low_rate_oscillator_clock_i;
			slow_s2_reg <= slow_s1_reg;
			slow_s3_reg <= slow_s2_reg;
			fast_s1_reg <= high_rate_oscillator_clock_i;
			fast_s2_reg <= fast_s1_reg;
			fast_s3_reg <= fast_s2_reg;
		end
	end

	// One-cycle pulses on each falling edge of the oscillators
	wire slow_fall = slow_s3_reg & ~slow_s2_reg;
	wire fast_fall = fast_s3_reg & ~fast_s2_reg;

	// ****************************************
	// Source select state machine
	// ****************************************
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [3:0] hold_cnt_reg;
	reg [3:0] hold_cnt_next;
	reg       sel_fast_reg;
	reg       sel_fast_next;
	reg       gap_reg;
	reg       gap_next;
	reg       fast_en_reg;
	reg       fast_en_next;
	reg       stop_mode_reg;
	reg       fast_done;
	reg       slow_done;

	wire cur_fall = sel_fast_reg ? fast_fall : slow_fall;
	wire to_slow  = halt_i | stop_i;

	always @* begin
		state_next    = state_reg;
		hold_cnt_next = hold_cnt_reg;
		sel_fast_next = sel_fast_reg;
		gap_next      = gap_reg;
		fast_en_next  = fast_en_reg;
		fast_done     = 1'b0;
		slow_done     = 1'b0;
		case (state_reg)
		ST_SLOW: begin
			if (IS_DUAL && fast_select_i && !to_slow) begin
				state_next    = ST_FAST_WAIT;
				fast_en_next  = 1'b1;
				hold_cnt_next = 4'h0;
			end
		end
		ST_FAST_WAIT: begin
			if (to_slow || slow_select_i) begin
				state_next   = ST_SLOW;
				fast_en_next = 1'b0;
			end else if (fast_fall) begin
				// Start-up edges are counted, the base clock stays slow
				if (hold_cnt_reg == `DCS_FAST_HOLD - 4'h1) begin
					state_next = ST_FAST_SWAP;
				end
				hold_cnt_next = hold_cnt_reg + 4'h1;
			end
		end
		ST_FAST_SWAP, ST_SLOW_SWAP: begin
			// Park low on the old source's fall, resume on the new one's;
			// while parked the select already names the new source
			if (state_reg == ST_FAST_SWAP && to_slow && !gap_reg) begin
				state_next   = ST_SLOW;
				fast_en_next = 1'b0;
			end else if (state_reg == ST_FAST_SWAP && to_slow) begin
				// Still parked low: point back at slow, resume on its fall
				state_next    = ST_SLOW_SWAP;
				sel_fast_next = 1'b0;
			end else if (!gap_reg && cur_fall) begin
				gap_next      = 1'b1;
				sel_fast_next = ~sel_fast_reg;
			end else if (gap_reg && cur_fall) begin
				gap_next = 1'b0;
				if (state_reg == ST_FAST_SWAP) begin
					state_next = ST_FAST;
					fast_done  = 1'b1;
				end else begin
					state_next   = ST_SLOW;
					fast_en_next = 1'b0;
					slow_done    = 1'b1;
				end
			end
		end
		ST_FAST: begin
			if (to_slow) begin
				state_next = ST_SLOW_SWAP;
			end else if (slow_select_i) begin
				state_next    = ST_SLOW_WAIT;
				hold_cnt_next = 4'h0;
			end
		end
		ST_SLOW_WAIT: begin
			if (to_slow) begin
				state_next = ST_SLOW_SWAP;
			end else if (slow_fall) begin
				if (hold_cnt_reg == `DCS_SLOW_HOLD - 4'h1) begin
					state_next = ST_SLOW_SWAP;
				end
				hold_cnt_next = hold_cnt_reg + 4'h1;
			end
		end
		default: begin
			state_next = ST_SLOW;
		end
		endcase
	end

	// Single options keep the machine parked in ST_SLOW with sel_fast_reg low
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg    <= ST_SLOW;
			hold_cnt_reg <= 4'h0;
			sel_fast_reg <= 1'b0;
			gap_reg      <= 1'b0;
			fast_en_reg  <= 1'b0;
		end else if (IS_DUAL) begin
			state_reg    <= state_next;
			hold_cnt_reg <= hold_cnt_next;
			sel_fast_reg <= sel_fast_next;
			gap_reg      <= gap_next;
			fast_en_reg  <= fast_en_next;
		end
	end

	// ****************************************
	// Stop mode and oscillator enables
	// ****************************************
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			stop_mode_reg <= 1'b0;
		end else if (stop_i) begin
			stop_mode_reg <= 1'b1;
		end else if (stop_exit_i) begin
			stop_mode_reg <= 1'b0;
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			low_rate_oscillator_en_o  <= 1'b0;
			high_rate_oscillator_en_o <= 1'b0;
			fast_freq_500k_o          <= 1'b0;
			base_clk_o                <= 1'b0;
			base_on_fast_o            <= 1'b0;
		end else begin
			low_rate_oscillator_en_o  <= !IS_FAST && !stop_mode_reg;
			high_rate_oscillator_en_o <= IS_FAST ? !stop_mode_reg : fast_en_reg;
			fast_freq_500k_o          <= (FAST_FREQ == `DCS_FREQ_500K);
			if (IS_FAST) begin
				base_clk_o     <= fast_s2_reg;
				base_on_fast_o <= 1'b1;
			end else begin
				base_clk_o     <= gap_reg ? 1'b0 : (sel_fast_reg ? fast_s2_reg : slow_s2_reg);
				base_on_fast_o <= sel_fast_reg;
			end
		end
	end

	// ****************************************
	// Pre-divider input and counter
	// ****************************************
	reg  [4:0]  ratio_cnt_reg;
	reg  [14:0] pdiv_next;
	wire        ratio_hit = (ratio_cnt_reg == DIV_LAST);
	wire        ph0_tick  = IS_FAST ? (fast_fall && ratio_hit) : slow_fall;
	wire        pdiv_clr  = predivider_clear_instruction_i &&
	                        (clear_operand_i == `DCS_CLR_OPERAND);
	wire        tap_rise;

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			ratio_cnt_reg <= 5'h00;
		end else if (fast_fall) begin
			ratio_cnt_reg <= ratio_hit ? 5'h00 : ratio_cnt_reg + 5'h01;
		end
	end

	always @* begin
		pdiv_next = predivider_o;
		if (ph0_tick) begin
			pdiv_next = predivider_o + 15'h0001;
		end
		if (pdiv_clr) begin
			pdiv_next[`DCS_TAP_FIFTEEN:`DCS_TAP_ELEVEN] = 5'h00;
		end
	end

	assign tap_rise = ph0_tick && !predivider_o[`DCS_TAP_FOURTEEN] &&
	                  pdiv_next[`DCS_TAP_FOURTEEN];

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			predivider_o  <= `DCS_PDIV_RST;
			periph_tick_o <= 1'b0;
		end else begin
			predivider_o  <= pdiv_next;
			periph_tick_o <= ph0_tick;
		end
	end

	// ****************************************
	// Registers and interrupt
	// ****************************************
	reg [2:0] ctrl_reg;
	reg [3:0] status_reg;
	reg [3:0] status_set;
	reg [3:0] mask_reg;
	wire      wake_release = tap_rise && ctrl_reg[`DCS_CTRL_HRE];
	wire      st_rd = reg_rd_i && (reg_addr_i == `DCS_ADDR_STATUS);

	always @* begin
		status_set = 4'h0;
		status_set[`DCS_ST_WAKE]     = tap_rise;
		status_set[`DCS_ST_START7]   = wake_release;
		status_set[`DCS_ST_FASTDONE] = fast_done;
		status_set[`DCS_ST_SLOWDONE] = slow_done;
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_reg   <= `DCS_CTRL_RST;
			mask_reg   <= `DCS_MASK_RST;
			status_reg <= `DCS_STATUS_RST;
		end else begin
			if (reg_wr_i && reg_addr_i == `DCS_ADDR_CTRL) begin
				ctrl_reg <= reg_wdata_i[2:0];
			end
			if (!IS_DUAL && stop_i) begin
				ctrl_reg[`DCS_CTRL_BOOST] <= 1'b1;
			end
			if (reg_wr_i && reg_addr_i == `DCS_ADDR_MASK) begin
				mask_reg <= reg_wdata_i[3:0];
			end
			// A set in the read cycle survives the clear
			status_reg <= (st_rd ? 4'h0 : status_reg) | status_set;
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o             <= 8'h00;
			irq_o                   <= 1'b0;
			halt_release_o          <= 1'b0;
			oscillator_boost_flag_o <= 1'b1;
		end else begin
			reg_rdata_o <= 8'h00;
			if (reg_rd_i) begin
				case (reg_addr_i)
				`DCS_ADDR_CTRL:   reg_rdata_o <= {5'h00, ctrl_reg};
				`DCS_ADDR_STATUS: reg_rdata_o <= {4'h0, status_reg};
				`DCS_ADDR_MASK:   reg_rdata_o <= {4'h0, mask_reg};
				`DCS_ADDR_STATE:  reg_rdata_o <= {1'b0, state_reg, 1'b0,
				                                  stop_mode_reg, fast_en_reg, sel_fast_reg};
				default:          reg_rdata_o <= 8'h00;
				endcase
			end
			// Wake bit interrupts only with its enable set as well
			irq_o <= |(status_reg & mask_reg &
			           {3'h7, ctrl_reg[`DCS_CTRL_IE]});
			halt_release_o          <= wake_release;
			oscillator_boost_flag_o <= ctrl_reg[`DCS_CTRL_BOOST];
		end
	end

endmodule

`default_nettype wire

// ---- tb/dcs_osc_model.sv ----
// Oscillator pins seen from the clock switch: one slow and one fast source.
// Assumes the enables come straight from the block under test.
`timescale 1ns/1ps
`default_nettype none
module dcs_osc_model #(
	parameter real SLOW_HALF = 12.3,
	parameter real FAST_HALF = 9.1
) (
	input  wire logic slow_en_i,
	input  wire logic fast_en_i,
	output var  logic slow_clk_o,
	output var  logic fast_clk_o
);
	// ********
	// Sources
	// ********
	// A disabled source finishes its high phase, then rests low
	initial begin
		slow_clk_o = 1'b0;
		forever begin
			#(SLOW_HALF);
			if (slow_en_i || slow_clk_o)
				slow_clk_o = ~slow_clk_o;
		end
	end
	initial begin
		fast_clk_o = 1'b0;
		forever begin
			#(FAST_HALF);
			if (fast_en_i || fast_clk_o)
				fast_clk_o = ~fast_clk_o;
		end
	end
endmodule
`default_nettype wire

// ---- tb/dcs_clock_switch_monitor.sv ----
// Assertion checker for the clock switch block, bound to its ports.
// Assumes the oscillator pins toggle far slower than clk_i.
`timescale 1ns/1ps
`default_nettype none
module dcs_clock_switch_monitor #(
	parameter logic [1:0] CLOCK_COMBO = 2'h0
) (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        low_rate_oscillator_clock_i,
	input wire logic        high_rate_oscillator_clock_i,
	input wire logic        fast_select_i,
	input wire logic        halt_i,
	input wire logic        predivider_clear_instruction_i,
	input wire logic        base_on_fast_o,
	input wire logic        high_rate_oscillator_en_o,
	input wire logic        low_rate_oscillator_en_o,
	input wire logic        periph_tick_o,
	input wire logic [14:0] predivider_o,
	input wire logic        halt_release_o
);
	// ********
	// Raw fast falls while enabled
	// ********
	// Raw pin leads the synced view, so this count is an upper bound
	logic       fast_d_reg;
	logic [3:0] falls_reg;
	always_ff @(posedge clk_i) begin
		fast_d_reg <= high_rate_oscillator_clock_i;
		if (sys_rst_i || !high_rate_oscillator_en_o)
			falls_reg <= 4'h0;
		else if (fast_d_reg && !high_rate_oscillator_clock_i && falls_reg != 4'hF)
			falls_reg <= falls_reg + 4'h1;
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_fast_start: assert property (
		CLOCK_COMBO == 2'h0 && fast_select_i && low_rate_oscillator_en_o &&
		!high_rate_oscillator_en_o
		|-> ##2 high_rate_oscillator_en_o) else $error("fast source not started");
	a_fast_hold: assert property (
		$rose(base_on_fast_o) |-> falls_reg >= 4'hC) else $error("fast swap too early");
	a_halt_slow: assert property (
		halt_i && base_on_fast_o |-> ##[1:40] !base_on_fast_o) else $error("halt kept fast");
	a_fast_off: assert property (
		$fell(base_on_fast_o) |-> ##[0:12] !high_rate_oscillator_en_o)
		else $error("fast source left on");
	a_single_idle: assert property (
		CLOCK_COMBO == 2'h1 |-> !high_rate_oscillator_en_o && !base_on_fast_o)
		else $error("single option left slow");
	a_fast_live: assert property (
		base_on_fast_o |-> high_rate_oscillator_en_o) else $error("fast base, source off");
	a_tick_slow: assert property (
		$fell(low_rate_oscillator_clock_i) && low_rate_oscillator_en_o
		|-> ##[1:5] periph_tick_o) else $error("slow fall without tick");
	a_div_step: assert property (
		$changed(predivider_o) && !$past(predivider_clear_instruction_i)
		|-> predivider_o == $past(predivider_o) + 15'h0001) else $error("divider skipped");
	a_wake_pulse: assert property (
		halt_release_o |-> predivider_o[13] ##1 !halt_release_o) else $error("bad release");
	c_fast: cover property ($rose(base_on_fast_o));
	c_slow: cover property ($fell(base_on_fast_o));
	c_wake: cover property (halt_release_o);
endmodule
bind dcs_clock_switch dcs_clock_switch_monitor #(.CLOCK_COMBO(CLOCK_COMBO))
	i_dcs_clock_switch_monitor (
	.clk_i, .sys_rst_i, .low_rate_oscillator_clock_i, .high_rate_oscillator_clock_i,
	.fast_select_i, .halt_i, .predivider_clear_instruction_i, .base_on_fast_o,
	.high_rate_oscillator_en_o, .low_rate_oscillator_en_o, .periph_tick_o,
	.predivider_o, .halt_release_o);
`default_nettype wire

// ---- tb/test_dcs_clock_switch.sv ----
// Self-checking bench for the clock switch block in the dual option,
// with a slow-only copy on the same inputs beside it.
// Assumes the oscillator model drives both pins from the block's enables.
`timescale 1ns/1ps
`default_nettype none
module test_dcs_clock_switch;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [4:0]  ins = 5'h00;
	logic        predivider_clear_instruction_i = 1'b0;
	logic [11:0] clear_operand_i = 12'h000;
	logic [3:0]  reg_addr_i = 4'h0;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	wire         fast_select_i, slow_select_i, halt_i, stop_i, stop_exit_i;
	wire         low_rate_oscillator_clock_i, high_rate_oscillator_clock_i;
	wire  [7:0]  reg_rdata_o;
	wire  [14:0] predivider_o;
	wire         base_clk_o, base_on_fast_o, high_rate_oscillator_en_o, fast_freq_500k_o;
	wire         low_rate_oscillator_en_o, oscillator_boost_flag_o, periph_tick_o;
	wire         halt_release_o, irq_o;
	wire         s_on_fast, s_fast_en, s_boost;
	int          errors = 0;
	int          total_checks = 0;
	int          n;
	assign {stop_exit_i, stop_i, halt_i, slow_select_i, fast_select_i} = ins;
	always #2 clk_i = ~clk_i;
	dcs_clock_switch i_dcs_clock_switch (
		.clk_i, .sys_rst_i, .low_rate_oscillator_clock_i, .high_rate_oscillator_clock_i,
		.fast_select_i, .slow_select_i, .halt_i, .stop_i, .stop_exit_i,
		.predivider_clear_instruction_i, .clear_operand_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .base_clk_o, .base_on_fast_o,
		.high_rate_oscillator_en_o, .fast_freq_500k_o, .low_rate_oscillator_en_o,
		.oscillator_boost_flag_o, .periph_tick_o, .predivider_o, .halt_release_o, .irq_o);
	dcs_clock_switch #(.CLOCK_COMBO(2'h1)) i_dcs_clock_switch_single (
		.clk_i, .sys_rst_i, .low_rate_oscillator_clock_i, .high_rate_oscillator_clock_i,
		.fast_select_i, .slow_select_i, .halt_i, .stop_i, .stop_exit_i,
		.predivider_clear_instruction_i, .clear_operand_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o (), .base_clk_o (), .base_on_fast_o (s_on_fast),
		.high_rate_oscillator_en_o (s_fast_en), .fast_freq_500k_o (),
		.low_rate_oscillator_en_o (), .oscillator_boost_flag_o (s_boost),
		.periph_tick_o (), .predivider_o (), .halt_release_o (), .irq_o ());
	dcs_osc_model i_dcs_osc_model (
		.slow_en_i  (low_rate_oscillator_en_o),
		.fast_en_i  (high_rate_oscillator_en_o),
		.slow_clk_o (low_rate_oscillator_clock_i),
		.fast_clk_o (high_rate_oscillator_clock_i));
	// ********
	// Tasks
	// ********
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask
	task automatic close_out();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Mask lets a read clear sticky bits whose value is not of interest
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o & m, e);
	endtask
	task automatic pulse(input logic [4:0] v);
		@(posedge clk_i);
		ins <= v;
		@(posedge clk_i);
		ins <= 5'h00;
	endtask
	task automatic clr(input logic [11:0] op, input logic [4:0] e);
		@(posedge clk_i);
		clear_operand_i <= op;
		predivider_clear_instruction_i <= 1'b1;
		@(posedge clk_i);
		predivider_clear_instruction_i <= 1'b0;
		#1;
		chk(predivider_o[14:10], e);
	endtask
	// 0: base on fast, 1: base on slow, 2: halt release pulse
	task automatic wait_for(input int w, input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge clk_i);
			#1;
			if ((w < 2 && base_on_fast_o === (w == 0)) || (w == 2 && halt_release_o === 1'b1))
				break;
		end
		if (n >= lim) begin
			errors++;
			close_out();
		end
	endtask
	// ********
	// Sequence
	// ********
	initial begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk(oscillator_boost_flag_o, 1'b1);
		chk(fast_freq_500k_o, 1'b0);
		chk(low_rate_oscillator_en_o, 1'b1);
		rd(4'h0, 8'h04, 8'hFF);
		rd(4'h1, 8'h00, 8'hFF);
		wr(4'hF, 8'h5A);
		rd(4'hF, 8'h00, 8'hFF);
		wr(4'h2, 8'h0F);
		rd(4'h2, 8'h0F, 8'hFF);
		wr(4'h0, 8'h03);
		rd(4'h0, 8'h03, 8'hFF);
		chk(oscillator_boost_flag_o, 1'b0);
		chk(s_boost, 1'b0);
		pulse(5'h01);
		repeat (2) @(posedge clk_i);
		#1;
		chk(high_rate_oscillator_en_o, 1'b1);
		wait_for(0, 400);
		chk(n >= 50, 1'b1);
		chk(s_on_fast, 1'b0);
		chk(s_fast_en, 1'b0);
		repeat (8) @(posedge clk_i);
		#1;
		chk(irq_o, 1'b1);
		rd(4'h1, 8'h04, 8'hFF);
		rd(4'h3, 8'h33, 8'hFF);
		chk(irq_o, 1'b0);
		pulse(5'h02);
		wait_for(1, 200);
		chk(n >= 6, 1'b1);
		repeat (12) @(posedge clk_i);
		#1;
		chk(high_rate_oscillator_en_o, 1'b0);
		rd(4'h1, 8'h08, 8'hFF);
		pulse(5'h01);
		wait_for(0, 400);
		pulse(5'h04);
		wait_for(1, 40);
		repeat (8) @(posedge clk_i);
		rd(4'h3, 8'h00, 8'hFF);
		rd(4'h1, 8'h00, 8'h00);
		pulse(5'h08);
		repeat (3) @(posedge clk_i);
		#1;
		chk(low_rate_oscillator_en_o, 1'b0);
		chk(s_boost, 1'b1);
		chk(oscillator_boost_flag_o, 1'b0);
		rd(4'h3, 8'h04, 8'hFF);
		pulse(5'h10);
		repeat (3) @(posedge clk_i);
		#1;
		chk(low_rate_oscillator_en_o, 1'b1);
		wait_for(2, 60000);
		chk(predivider_o[13], 1'b1);
		@(posedge clk_i);
		#1;
		chk(irq_o, 1'b1);
		wr(4'h2, 8'h0C);
		@(posedge clk_i);
		#1;
		chk(irq_o, 1'b0);
		rd(4'h1, 8'h03, 8'hFF);
		clr(12'h0FF, 5'h08);
		clr(12'h100, 5'h00);
		close_out();
	end
endmodule
`default_nettype wire
